// ===== src/lsc_supply_ctrl.v
`include "lsc_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module lsc_supply_ctrl (
  input wire sys_clk_in,
  input wire rst_b_in,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_out,
  input wire [1:0] addr_strap_in,
  input wire supply_ok_in,
  input wire current_limit_in,
  input wire thermal_trip_in,
  input wire tone_gate_in,
  input wire tone_sense_in,
  output reg tone_detect_out,
  output reg tone_detect_oe_out,
  output reg tone_on_out,
  output reg power_enable_out,
  output reg loop_through_closed_out,
  output reg [1:0] level_sel_out,
  output reg current_limit_low_out,
  output reg static_limit_mode_out,
  output reg [7:0] control_byte_out
);
  // Protocol states
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_AACK = 3'h2;
  localparam ST_WDATA = 3'h3;
  localparam ST_WACK = 3'h4;
  localparam ST_RDATA = 3'h5;
  localparam ST_RACK = 3'h6;

  // Two-flop synchronisers for all asynchronous inputs, one vector per stage
  reg [8:0] sync_a;
  reg [8:0] sync_b;
  reg scl_d; // Previous synchronised clock, for edge finding
  reg sda_d; // Previous synchronised data, for start/stop finding
  reg [2:0] state; // Protocol state
  reg [2:0] bit_cnt; // Index of current bit in byte, counting down from 7
  reg [7:0] shift; // Receive shift register
  reg [7:0] tx; // Transmit shift register
  reg [5:0] ctrl_hi; // Writable upper six bits
  reg is_read; // Transfer direction latched from address byte
  // Eighth bit is in; the next falling clock decides the acknowledge.
  // A bare count cannot tell this apart from the fall that follows a start.
  reg byte_full;
  wire [8:0] raw_in;
  wire scl_s;
  wire sda_s;
  wire [1:0] strap_s;
  wire sup_s;
  wire lim_s;
  wire therm_s;
  wire gate_s;
  wire sense_s;
  wire scl_rise;
  wire scl_fall;
  wire start_cond;
  wire stop_cond;
  wire [7:0] ctrl_full;
  wire [6:0] my_addr;

  assign raw_in = {scl_in, sda_in, addr_strap_in, supply_ok_in, current_limit_in,
                   thermal_trip_in, tone_gate_in, tone_sense_in};
  assign {scl_s, sda_s, strap_s, sup_s, lim_s, therm_s, gate_s, sense_s} = sync_b;

  // Synchronise every pin; only the second stage is read by logic
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync_a <= 9'h180;
      sync_b <= 9'h180;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      sync_a <= raw_in;
      sync_b <= sync_a;
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Edges and bus conditions; the sampled clock is 250x the fastest bit rate
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_cond = scl_s & scl_d & ~sda_d & sda_s;
  // Strap band picks one of four consecutive addresses
  assign my_addr = `LSC_ADDR_BASE + {5'h00, strap_s};
  // Flags reflect live protection state, never stored writes
  assign ctrl_full = {ctrl_hi, therm_s, lim_s};

  // Byte-level protocol engine
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= ST_IDLE;
      bit_cnt <= 3'h7;
      shift <= 8'h00;
      tx <= 8'h00;
      ctrl_hi <= 6'h00;
      is_read <= 1'b0;
      byte_full <= 1'b0;
      sda_out <= 1'b0;
      sda_oe_out <= 1'b0;
    end else if (!sup_s) begin
      // Undervoltage: byte cleared, bus ignored until supply recovers
      state <= ST_IDLE;
      ctrl_hi <= 6'h00;
      sda_oe_out <= 1'b0;
    end else if (start_cond) begin
      // Start (or repeated start) restarts address reception whenever supply is good
      state <= ST_ADDR;
      bit_cnt <= 3'h7;
      byte_full <= 1'b0; // Partial byte from before the start is dropped
      sda_oe_out <= 1'b0;
    end else if (stop_cond) begin
      state <= ST_IDLE;
      sda_oe_out <= 1'b0;
    end else begin
      case (state)
        ST_ADDR, ST_WDATA: begin
          if (scl_rise) begin
            shift <= {shift[6:0], sda_s};
            bit_cnt <= bit_cnt - 3'h1;
            // Last of eight rises completes the byte
            if (bit_cnt == 3'h0) begin
              byte_full <= 1'b1;
            end
          end
          // After eighth bit, at falling clock, decide on acknowledge
          if (scl_fall && byte_full) begin
            byte_full <= 1'b0;
            if (state == ST_ADDR) begin
              if (shift[7:1] == my_addr) begin
                sda_out <= 1'b0;
                sda_oe_out <= 1'b1;
                is_read <= shift[0];
                state <= ST_AACK;
              end else begin
                state <= ST_IDLE; // Not ours: stay off the bus
              end
            end else begin
              // Full byte in hand: only the upper six bits land
              ctrl_hi <= shift[7:2];
              sda_out <= 1'b0;
              sda_oe_out <= 1'b1;
              state <= ST_WACK;
            end
          end
        end
        ST_AACK, ST_WACK: begin
          // Release ack after the ninth clock; preload readback if reading
          if (scl_fall) begin
            bit_cnt <= 3'h7;
            if (state == ST_AACK && is_read) begin
              tx <= {ctrl_full[6:0], 1'b0};
              sda_out <= ctrl_full[7];
              sda_oe_out <= ~ctrl_full[7];
              state <= ST_RDATA;
            end else begin
              sda_oe_out <= 1'b0;
              state <= ST_WDATA;
            end
          end
        end
        ST_RDATA: begin
          // Open-drain: drive only zeros, release for ones
          if (scl_fall) begin
            if (bit_cnt == 3'h0) begin
              sda_oe_out <= 1'b0;
              state <= ST_RACK;
            end else begin
              sda_out <= tx[7];
              sda_oe_out <= ~tx[7];
              tx <= {tx[6:0], 1'b0};
              bit_cnt <= bit_cnt - 3'h1;
            end
          end
        end
        ST_RACK: begin
          // Ninth clock: master ack sends another copy, nack ends
          if (scl_rise) begin
            if (!sda_s) begin
              state <= ST_AACK;
              is_read <= 1'b1;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Power-stage controls, all registered
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      power_enable_out <= 1'b0;
      loop_through_closed_out <= 1'b1;
      level_sel_out <= `LSC_LEVEL_13V;
      current_limit_low_out <= 1'b0;
      static_limit_mode_out <= 1'b0;
      tone_on_out <= 1'b0;
      tone_detect_out <= 1'b0;
      tone_detect_oe_out <= 1'b0;
      control_byte_out <= `LSC_CTRL_RESET;
    end else begin
      power_enable_out <= ctrl_full[`LSC_BIT_POWER_EN] & sup_s;
      loop_through_closed_out <= ~(ctrl_full[`LSC_BIT_POWER_EN] & sup_s);
      // Level code: {line comp, volt select} gives 13/18/14/19 V
      level_sel_out <= {ctrl_full[`LSC_BIT_LINE_COMP], ctrl_full[`LSC_BIT_VOLT_SEL]};
      current_limit_low_out <= ctrl_full[`LSC_BIT_CURRENT_LOW];
      static_limit_mode_out <= ctrl_full[`LSC_BIT_STATIC_LIMIT];
      // Tone follows gate pin unless forced; nothing while power is off
      tone_on_out <= ctrl_full[`LSC_BIT_POWER_EN] &
                     (ctrl_full[`LSC_BIT_TONE_FORCE] | gate_s);
      // Open drain: pull low while tone sensed, else release
      tone_detect_out <= 1'b0;
      tone_detect_oe_out <= sense_s;
      control_byte_out <= ctrl_full;
    end
  end
endmodule
`default_nettype wire

// ===== src/lsc_consts.vh
`ifndef LSC_CONSTS_VH
`define LSC_CONSTS_VH
// Slave address base; the strap band adds 0..3 to it
`define LSC_ADDR_BASE 7'h08
// Control byte field positions
`define LSC_BIT_STATIC_LIMIT 7
`define LSC_BIT_CURRENT_LOW 6
`define LSC_BIT_TONE_FORCE 5
`define LSC_BIT_LINE_COMP 4
`define LSC_BIT_VOLT_SEL 3
`define LSC_BIT_POWER_EN 2
`define LSC_BIT_OVERTEMP 1
`define LSC_BIT_OVERLOAD 0
// Writable bits mask and reset value
`define LSC_WRITE_MASK 8'hfc
`define LSC_CTRL_RESET 8'h00
// Output level codes: 0=13V, 1=18V, 2=14V, 3=19V
`define LSC_LEVEL_13V 2'h0
`define LSC_LEVEL_18V 2'h1
`define LSC_LEVEL_14V 2'h2
`define LSC_LEVEL_19V 2'h3
// Fastest bus bit rate in kbit/s and system clock in kHz
`define LSC_MAX_RATE_KBPS 400
`define LSC_CLK_KHZ 100000
// Least system clocks per bus bit, rounded up
`define LSC_MIN_BIT_CYCLES ((`LSC_CLK_KHZ + `LSC_MAX_RATE_KBPS - 1) / `LSC_MAX_RATE_KBPS)
`endif

// ===== verif/lsc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Stand-in for the bus master; released lines read back high through the pull-up
module lsc_host_model (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  // Quarter bit of 4 clocks gives a 160 ns bus clock; faster than the rated
  // bus to keep the run short, still 8 system clocks per clock phase
  task automatic step(input logic c, input logic d);
    scl_out = c;
    sda_out = d;
    repeat (4) @(negedge clk_in);
  endtask
  // Data falls while the clock is high; also serves as repeated start
  task automatic start();
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask
  task automatic stop();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask
  // Nine bits MSB first; bit 0 is the acknowledge slot, 1 releases it
  task automatic xfer(input logic [8:0] t, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      step(1'b0, t[i]);
      step(1'b1, t[i]);
      r[i] = sda_in;
      step(1'b1, t[i]);
      step(1'b0, t[i]);
    end
  endtask
endmodule
`default_nettype wire

// ===== verif/lsc_supply_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
// Pin decoding of the control byte, judged once inputs have settled
module lsc_chk (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic supply_ok_in,
  input wire logic current_limit_in,
  input wire logic thermal_trip_in,
  input wire logic tone_gate_in,
  input wire logic tone_sense_in,
  input wire logic [7:0] control_byte_out,
  input wire logic power_enable_out,
  input wire logic loop_through_closed_out,
  input wire logic [1:0] level_sel_out,
  input wire logic current_limit_low_out,
  input wire logic static_limit_mode_out,
  input wire logic tone_on_out,
  input wire logic tone_detect_oe_out,
  input wire logic tone_detect_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  wire [7:0] cb = control_byte_out;
  // Five quiet cycles cover the input sync plus the output register
  sequence s_set;
    $stable({cb[7:2], tone_gate_in, tone_sense_in, supply_ok_in})[*5];
  endsequence
  sequence s_on;
    s_set ##0 cb[2];
  endsequence
  property p_power;
    s_set |-> power_enable_out == cb[2] && loop_through_closed_out == !cb[2];
  endproperty
  a_power: assert property (p_power) else $error("power gating wrong");
  property p_level;
    s_on |-> level_sel_out == cb[4:3];
  endproperty
  a_level: assert property (p_level) else $error("level wrong");
  property p_limit;
    s_on |-> current_limit_low_out == cb[6] && static_limit_mode_out == cb[7];
  endproperty
  a_limit: assert property (p_limit) else $error("limit wrong");
  property p_tone;
    s_set |-> tone_on_out == (cb[2] && (cb[5] || tone_gate_in));
  endproperty
  a_tone: assert property (p_tone) else $error("tone wrong");
  property p_detect;
    s_set |-> tone_detect_oe_out == tone_sense_in && !tone_detect_out;
  endproperty
  a_detect: assert property (p_detect) else $error("detect wrong");
  property p_uv;
    !supply_ok_in [*5] |-> cb[7:2] == 6'h00;
  endproperty
  a_uv: assert property (p_uv) else $error("undervoltage kept bits");
  property p_flags;
    $stable({supply_ok_in, current_limit_in, thermal_trip_in})[*5] ##0 supply_ok_in
      |-> cb[1:0] == {thermal_trip_in, current_limit_in};
  endproperty
  a_flags: assert property (p_flags) else $error("flags wrong");
  property p_reset;
    $rose(rst_b_in) |-> (cb[7:2] == 6'h00) [*3];
  endproperty
  a_reset: assert property (p_reset) else $error("reset value wrong");
endmodule
bind lsc_supply_ctrl lsc_chk u_lsc_chk (.*);
`default_nettype wire

// ===== verif/lsc_supply_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module lsc_supply_ctrl_tb_top;
  logic clk = 1'b0, rst_b = 1'b0, ok = 1'b1, cl = 1'b0, tt = 1'b0, gate = 1'b0, sense = 1'b0;
  logic [1:0] strap = 2'h0;
  logic [7:0] cur = 8'h00;
  logic [8:0] got;
  logic [8:0] exp_q[$];
  int n_mismatch = 0;
  int checked = 0;
  event got_ev;
  wire scl, sda_h, oe, sdo;
  wire [7:0] cbo;
  // Open-drain data line with a pull-up
  wire sda = sda_h & (oe ? sdo : 1'b1);
  // Host pulls the bypass input low while it keys the tone, else floats it
  wire bypass_ctl = gate ? 1'b0 : 1'bz;
  lsc_host_model u_lsc_host_model (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_out(sda_h));
  lsc_supply_ctrl u_lsc_supply_ctrl (.sys_clk_in(clk), .rst_b_in(rst_b), .scl_in(scl),
    .sda_in(sda), .sda_out(sdo), .sda_oe_out(oe), .addr_strap_in(strap), .supply_ok_in(ok),
    .current_limit_in(cl), .thermal_trip_in(tt), .tone_gate_in(gate), .tone_sense_in(sense),
    .tone_detect_out(), .tone_detect_oe_out(), .tone_on_out(), .power_enable_out(),
    .loop_through_closed_out(), .level_sel_out(), .current_limit_low_out(),
    .static_limit_mode_out(), .control_byte_out(cbo));
  task automatic give_verdict();
    $display("mismatches %0d of %0d checks", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [8:0] e, input logic [8:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // Driver notes the expectation, then the watcher compares the result
  task automatic xf(input logic [8:0] t, input logic [8:0] e);
    exp_q.push_back(e);
    u_lsc_host_model.xfer(t, got);
    -> got_ev;
  endtask
  task automatic note(input logic [7:0] e);
    exp_q.push_back({1'b0, e});
    got = {1'b0, cbo};
    -> got_ev;
  endtask
  // Write then read twice; a refused session must leave the byte alone
  task automatic sess(input logic [6:0] a, input logic [7:0] d, input logic ack);
    logic [7:0] r;
    if (ack) cur = {d[7:2], 2'b00};
    r = ack ? (cur | {6'h00, tt, cl}) : 8'hff;
    u_lsc_host_model.start();
    xf({a, 2'b01}, {a, 1'b0, !ack});
    xf({d, 1'b1}, {d, !ack});
    u_lsc_host_model.start();
    xf({a, 2'b11}, {a, 1'b1, !ack});
    xf(9'h1fe, {r, 1'b0});
    xf(9'h1ff, {r, 1'b1});
    u_lsc_host_model.stop();
    note(cur | {6'h00, tt, cl});
  endtask
  always #5 clk = ~clk;
  always @(got_ev) chk(exp_q.pop_front(), got);
  initial begin
    void'($urandom(32'h748e0a30));
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    note(8'h00);
    for (int i = 0; i < 4; i++) begin
      strap = i[1:0];
      {cl, tt, gate, sense} = 4'($urandom);
      sess({5'h02, i[1:0]}, 8'($urandom), 1'b1);
      sess({5'h02, i[1:0] + 2'h1}, 8'($urandom), 1'b0);
    end
    {cl, tt} = 2'h0;
    ok = 1'b0;
    cur = 8'h00;
    repeat (8) @(negedge clk);
    note(8'h00);
    sess(7'h0b, 8'hfc, 1'b0);
    ok = 1'b1;
    repeat (8) @(negedge clk);
    sess(7'h0b, 8'hfc, 1'b1);
    @(negedge clk);
    give_verdict();
  end
  // Whole run needs about 77 us
  initial begin
    #500000;
    n_mismatch++;
    give_verdict();
  end
endmodule
`default_nettype wire
